// >>> inc/lp3_link_if.sv
// Sampled link events passed from the pin sampler to the state machine.
`timescale 1ns/1ps
interface lp3_link_if;
	logic       rise;
	logic       fall;
	logic       cke_cur;
	logic       cke_prev;
	logic       cs_n;
	logic [9:0] ca_r;
	logic [9:0] ca_f;

	modport smp (output rise, fall, cke_cur, cke_prev, cs_n, ca_r, ca_f);
	modport fsm (input rise, fall, cke_cur, cke_prev, cs_n, ca_r, ca_f);
endinterface

// >>> inc/lp3_pkg.sv
// Shared constants, timings and state types for the LPDDR3 power and bank state machine.
package lp3_pkg;

	// Core clock period; every wait below is converted with it.
	localparam int MCLK_NS = 25;

	// Least-time conversion: round up, never below one cycle.
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + MCLK_NS - 1) / MCLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Device waits in nanoseconds (plain defaults) and their cycle counts.
	localparam int T_XP_NS    = 8;
	localparam int T_XSR_NS   = 220;
	localparam int T_INIT5_NS = 10000;
	localparam int T_MRW_NS   = 250;
	localparam int T_MRR_NS   = 100;
	localparam int T_RP_NS    = 30;
	localparam int T_RFCPB_NS = 90;
	localparam int T_RFCAB_NS = 210;
	localparam int C_XP       = cyc_min(T_XP_NS);
	localparam int C_XSR      = cyc_min(T_XSR_NS);
	localparam int C_INIT5    = cyc_min(T_INIT5_NS);
	localparam int C_MRW      = cyc_min(T_MRW_NS);
	localparam int C_MRR      = cyc_min(T_MRR_NS);
	localparam int C_RP       = cyc_min(T_RP_NS);
	localparam int C_RFCPB    = cyc_min(T_RFCPB_NS);
	localparam int C_RFCAB    = cyc_min(T_RFCAB_NS);

	// Geometry and field positions on the command/address bus.
	localparam int NBANK  = 8;
	localparam int CA_W   = 10;
	localparam int TMR_W  = 12;
	localparam int MR_N   = 16;
	localparam int BA_LSB = 7;
	localparam int AB_BIT = 4;
	localparam int MA_LSB = 4;

	// Mode register addresses and value after reset.
	localparam logic [7:0] MA_RESET = 8'h3F;
	localparam logic [7:0] MA_ODT   = 8'h0B;
	localparam logic [7:0] MR_RST   = 8'h00;

	// Device-level states, one-hot.
	typedef enum logic [12:0] {
		D_PWRON = 13'h0001, D_RESET = 13'h0002, D_OPER  = 13'h0004,
		D_APD   = 13'h0008, D_IPD   = 13'h0010, D_RPD   = 13'h0020,
		D_SREF  = 13'h0040, D_DPD   = 13'h0080, D_MRW   = 13'h0100,
		D_MRRI  = 13'h0200, D_MRRA  = 13'h0400, D_MRRR  = 13'h0800,
		D_REFAB = 13'h1000
	} lp3_dev_t;

	// Per-bank states, one-hot.
	typedef enum logic [5:0] {
		B_IDLE = 6'h01, B_ACT = 6'h02, B_RD = 6'h04,
		B_WR   = 6'h08, B_PRE = 6'h10, B_REF = 6'h20
	} lp3_bank_t;

endpackage

// >>> sim/lp3_ctrl_model.sv
// Behavioural memory controller that drives the device's link pins.
`timescale 1ns/1ps
module lp3_ctrl_model (
	input wire logic   mclk,
	output logic       ck,
	output logic       cke,
	output logic       cs_n,
	output logic [9:0] ca
);
	// Link clock stopped low and the device deselected until the first command.
	initial begin
		ck = 1'b0;
		cke = 1'b1;
		cs_n = 1'b1;
		ca = 10'h155;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One link period of eight core cycles; pins move halfway between clock edges.
	// A deselected bus shows the inverse of its last value, since floated lines hold nothing.
	task automatic send(input logic k, input logic s, input logic [9:0] r, input logic [9:0] f);
		@(posedge mclk);
		cke <= k;
		cs_n <= s;
		ca <= s ? ~ca : r;
		repeat (2) @(posedge mclk);
		ck <= 1'b1;
		repeat (2) @(posedge mclk);
		ca <= s ? ~ca : f;
		repeat (2) @(posedge mclk);
		ck <= 1'b0;
		@(posedge mclk);
	endtask

	// Idle periods with the clock running cover exit waits before any real command.
	task automatic nops(input int n);
		repeat (n) send(1'b1, 1'b1, 10'h000, 10'h000);
	endtask
endmodule

// >>> sim/lp3_power_bank_fsm_props.sv
// Concurrent checks on the ports of the power and bank state machine.
`timescale 1ns/1ps
module lp3_power_bank_fsm_props #(
	parameter int NBANK   = lp3_pkg::NBANK,
	parameter int C_INIT5 = lp3_pkg::C_INIT5,
	parameter int C_XSR   = lp3_pkg::C_XSR,
	parameter int C_XP    = lp3_pkg::C_XP
) (
	input wire logic          mclk,
	input wire logic          rst_n,
	input wire logic          ck,
	input wire logic          cke,
	input wire logic          cs_n,
	input wire logic [9:0]    ca,
	input lp3_pkg::lp3_dev_t  dev_state,
	input lp3_pkg::lp3_bank_t bank_state [NBANK],
	input logic               nop_only,
	input logic               init_done,
	input logic [7:0]         mrr_data,
	input logic               dq_oe,
	input logic               dq_term_en
);
	logic lowpow;
	logic all_idle;
	int   nrun_q;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	// Low-power and all-banks-idle views of the state outputs.
	always_comb begin
		lowpow = dev_state inside {lp3_pkg::D_APD, lp3_pkg::D_IPD, lp3_pkg::D_RPD,
			lp3_pkg::D_SREF, lp3_pkg::D_DPD};
		all_idle = 1'b1;
		for (int i = 0; i < NBANK; i++) begin
			if (bank_state[i] != lp3_pkg::B_IDLE) begin
				all_idle = 1'b0;
			end
		end
	end

	// Run length of the exit wait; a wait that never ends shows as an overlong run.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			nrun_q <= 0;
		end else begin
			nrun_q <= nop_only ? nrun_q + 1 : 0;
		end
	end

	// The device has just left state s.
	sequence left_st(s);
		$past(dev_state) == s && dev_state != s;
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	hold_lowpow_a: assert property ((!cke) [*6] ##0 lowpow |=> $stable(dev_state))
		else $error("low-power state left while clock enable stayed low");
	apd_exit_a: assert property (left_st(lp3_pkg::D_APD) |-> dev_state == lp3_pkg::D_OPER)
		else $error("active power down left to a wrong state");
	ipd_exit_a: assert property (left_st(lp3_pkg::D_IPD) |-> dev_state == lp3_pkg::D_OPER)
		else $error("idle power down left to a wrong state");
	rpd_exit_a: assert property (left_st(lp3_pkg::D_RPD) |->
		dev_state == ($past(init_done) ? lp3_pkg::D_OPER : lp3_pkg::D_RESET))
		else $error("resetting power down left to a wrong state");
	dpd_exit_a: assert property (left_st(lp3_pkg::D_DPD) |-> dev_state == lp3_pkg::D_PWRON)
		else $error("deep power down left to a wrong state");
	sref_exit_a: assert property (left_st(lp3_pkg::D_SREF) |-> dev_state == lp3_pkg::D_OPER)
		else $error("self refresh left to a wrong state");
	nop_wait_a: assert property (nrun_q <= C_XSR)
		else $error("exit wait ran longer than the longest exit time");
	ipd_entry_a: assert property (
		$changed(dev_state) && dev_state == lp3_pkg::D_IPD |-> $past(all_idle))
		else $error("idle power down entered with a bank open");
	apd_entry_a: assert property (
		$changed(dev_state) && dev_state == lp3_pkg::D_APD |-> !$past(all_idle))
		else $error("active power down entered with all banks idle");
	mrw_entry_a: assert property (
		$changed(dev_state) && dev_state == lp3_pkg::D_MRW |->
		$past(dev_state) == lp3_pkg::D_OPER && $past(all_idle))
		else $error("mode register write state entered from a busy state");
	mrr_drive_a: assert property (
		dq_oe == (dev_state inside {lp3_pkg::D_MRRI, lp3_pkg::D_MRRA, lp3_pkg::D_MRRR}))
		else $error("data drive does not match the register read states");
	term_lowpow_a: assert property (dq_term_en |-> lowpow)
		else $error("termination enabled outside a low-power state");

	// Per-bank transitions may only come from the states the tables allow.
	for (genvar i = 0; i < NBANK; i++) begin : g_bank
		bank_act_a: assert property (
			$changed(bank_state[i]) && bank_state[i] == lp3_pkg::B_ACT |->
			$past(bank_state[i]) == lp3_pkg::B_IDLE) else $error("bank opened while not idle");
		bank_rd_a: assert property (
			$changed(bank_state[i]) && bank_state[i] == lp3_pkg::B_RD |->
			$past(bank_state[i]) inside {lp3_pkg::B_ACT, lp3_pkg::B_WR})
			else $error("read burst from a wrong bank state");
		bank_wr_a: assert property (
			$changed(bank_state[i]) && bank_state[i] == lp3_pkg::B_WR |->
			$past(bank_state[i]) inside {lp3_pkg::B_ACT, lp3_pkg::B_RD})
			else $error("write burst from a wrong bank state");
	end
endmodule

bind lp3_power_bank_fsm lp3_power_bank_fsm_props #(
	.NBANK(NBANK), .C_INIT5(C_INIT5), .C_XSR(C_XSR), .C_XP(C_XP)
) i_lp3_power_bank_fsm_props (
	.mclk(mclk), .rst_n(rst_n), .ck(ck), .cke(cke), .cs_n(cs_n), .ca(ca),
	.dev_state(dev_state), .bank_state(bank_state), .nop_only(nop_only),
	.init_done(init_done), .mrr_data(mrr_data), .dq_oe(dq_oe), .dq_term_en(dq_term_en)
);

// >>> sim/test_lp3_power_bank_fsm.sv
// Self-checking bench for the power and bank state machine.
`timescale 1ns/1ps
module test_lp3_power_bank_fsm;
	localparam int LIMIT = 4000;
	logic               mclk;
	logic               rst_n;
	logic               ck;
	logic               cke;
	logic               cs_n;
	logic [9:0]         ca;
	lp3_pkg::lp3_dev_t  dev_state;
	lp3_pkg::lp3_bank_t bank_state [lp3_pkg::NBANK];
	lp3_pkg::lp3_bank_t exp_bank   [lp3_pkg::NBANK];
	logic               nop_only;
	logic               init_done;
	logic [7:0]         mrr_data;
	logic               dq_oe;
	logic               dq_term_en;
	logic [7:0]         mrq [$];
	logic [7:0]         op;
	logic [2:0]         b;
	logic [3:0]         rw [5] = '{4'h5, 4'h5, 4'h1, 4'h1, 4'h5};
	int                 mismatches = 0;
	int                 samples_checked = 0;
	int                 cycles = 0;

	// Small init wait keeps the resetting scenarios short.
	lp3_power_bank_fsm #(.C_INIT5(40), .C_XSR(4), .C_XP(1)) i_lp3_power_bank_fsm (
		.mclk(mclk), .rst_n(rst_n), .ck(ck), .cke(cke), .cs_n(cs_n), .ca(ca),
		.dev_state(dev_state), .bank_state(bank_state), .nop_only(nop_only),
		.init_done(init_done), .mrr_data(mrr_data), .dq_oe(dq_oe), .dq_term_en(dq_term_en)
	);
	lp3_ctrl_model i_lp3_ctrl_model (.mclk(mclk), .ck(ck), .cke(cke), .cs_n(cs_n), .ca(ca));

	////////////////////////////////////////////////////////////////////////////////
	// Core clock and hang guard.
	initial mclk = 1'b0;
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			final_report();
		end
	end

	// Compares one value and counts the outcome.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t ns: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// Sends one command while polling, so short register access states are not missed.
	task automatic step(input logic k, input logic s, input logic [9:0] r, input logic [9:0] f,
		input lp3_pkg::lp3_dev_t e);
		fork
			i_lp3_ctrl_model.send(k, s, r, f);
			begin
				for (int n = 0; n < 14 && dev_state !== e; n++) begin
					@(negedge mclk);
				end
				chk(dev_state, e);
			end
		join
	endtask

	// Random pins while clock enable stays low.
	task automatic hold_low(input lp3_pkg::lp3_dev_t e, input int n);
		repeat (n) step(1'b0, 1'($urandom), 10'($urandom), 10'($urandom), e);
	endtask

	// Bank command: opcode and flags on the rising half, random column bits after.
	task automatic bcmd(input logic [3:0] c, input logic [2:0] bk, input logic ab);
		step(1'b1, 1'b0, {bk, 2'h0, ab, c}, 10'($urandom), lp3_pkg::D_OPER);
	endtask

	// Compares every bank with the model once any precharge time has run out.
	task automatic chk_banks();
		repeat (4) @(negedge mclk);
		for (int i = 0; i < lp3_pkg::NBANK; i++) begin
			chk(bank_state[i], exp_bank[i]);
		end
	endtask

	// Waits out the init interval, then one idle period that must find the device idle.
	task automatic wait_init();
		for (int n = 0; n < 80 && init_done !== 1'b1; n++) begin
			@(negedge mclk);
		end
		step(1'b1, 1'b1, 10'h000, 10'h000, lp3_pkg::D_OPER);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		rst_n = 1'b0;
		void'($urandom(44030));
		foreach (exp_bank[i]) begin
			exp_bank[i] = lp3_pkg::B_IDLE;
		end
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		chk(dev_state, lp3_pkg::D_PWRON);
		chk(init_done, 1'b1);
		chk(mrr_data, 8'h00);
		chk(dq_oe, 1'b0);
		chk_banks();
		$display("test reset values done");
		// The first link edge after reset only sets the previous clock enable level.
		i_lp3_ctrl_model.nops(1);
		// Resetting power down left before, and then after, the init wait ends.
		step(1'b1, 1'b0, 10'h3F0, 10'h000, lp3_pkg::D_RESET);
		chk(init_done, 1'b0);
		step(1'b1, 1'b0, 10'h0B8, 10'h000, lp3_pkg::D_MRRR);
		step(1'b0, 1'b1, 10'h000, 10'h000, lp3_pkg::D_RPD);
		hold_low(lp3_pkg::D_RPD, 1);
		step(1'b1, 1'b1, 10'h000, 10'h000, lp3_pkg::D_RESET);
		wait_init();
		step(1'b1, 1'b0, 10'h3F0, 10'h000, lp3_pkg::D_RESET);
		step(1'b0, 1'b1, 10'h000, 10'h000, lp3_pkg::D_RPD);
		hold_low(lp3_pkg::D_RPD, 6);
		step(1'b1, 1'b1, 10'h000, 10'h000, lp3_pkg::D_OPER);
		i_lp3_ctrl_model.nops(2);
		$display("test resetting power down done");
		// Termination register written and read back.
		op = 8'($urandom) | 8'h01;
		mrq.push_back(op);
		step(1'b1, 1'b0, 10'h0B0, {op, 2'b00}, lp3_pkg::D_MRW);
		i_lp3_ctrl_model.nops(2);
		step(1'b1, 1'b0, 10'h0B8, {8'($urandom), 2'h0}, lp3_pkg::D_MRRI);
		chk(dq_oe, 1'b1);
		i_lp3_ctrl_model.nops(1);
		chk(mrr_data, mrq.pop_front());
		// Idle power down with termination on, self refresh, deep power down.
		step(1'b0, 1'b1, 10'h000, 10'h000, lp3_pkg::D_IPD);
		chk(dq_term_en, |op[1:0]);
		hold_low(lp3_pkg::D_IPD, 3);
		step(1'b1, 1'b1, 10'h000, 10'h000, lp3_pkg::D_OPER);
		i_lp3_ctrl_model.nops(1);
		chk(dq_term_en, 1'b0);
		step(1'b0, 1'b0, 10'h004, 10'h000, lp3_pkg::D_SREF);
		hold_low(lp3_pkg::D_SREF, 2);
		step(1'b1, 1'b1, 10'h000, 10'h000, lp3_pkg::D_OPER);
		chk(nop_only, 1'b1);
		i_lp3_ctrl_model.nops(2);
		chk(nop_only, 1'b0);
		step(1'b0, 1'b0, 10'h003, 10'h000, lp3_pkg::D_DPD);
		hold_low(lp3_pkg::D_DPD, 1);
		step(1'b1, 1'b1, 10'h000, 10'h000, lp3_pkg::D_PWRON);
		i_lp3_ctrl_model.nops(2);
		step(1'b1, 1'b0, 10'h3F0, 10'h000, lp3_pkg::D_RESET);
		wait_init();
		$display("test low-power states done");
		// Bank commands on a random bank and its neighbour.
		b = 3'($urandom);
		bcmd(4'h2, b, 1'b0);
		exp_bank[b] = lp3_pkg::B_ACT;
		chk_banks();
		step(1'b0, 1'b1, 10'h000, 10'h000, lp3_pkg::D_APD);
		step(1'b1, 1'b1, 10'h000, 10'h000, lp3_pkg::D_OPER);
		i_lp3_ctrl_model.nops(1);
		bcmd(4'hB, b, 1'b0);
		exp_bank[b] = lp3_pkg::B_IDLE;
		chk_banks();
		bcmd(4'h2, b, 1'b0);
		bcmd(4'h2, 3'(b + 3'd1), 1'b0);
		bcmd(4'hB, 3'h0, 1'b1);
		chk_banks();
		bcmd(4'h2, b, 1'b0);
		exp_bank[b] = lp3_pkg::B_ACT;
		step(1'b1, 1'b0, 10'h0B8, 10'h000, lp3_pkg::D_MRRA);
		i_lp3_ctrl_model.nops(1);
		// Each burst is over before the other kind follows, eleven core cycles on.
		foreach (rw[i]) begin
			bcmd(rw[i], b, 1'b0);
			exp_bank[b] = rw[i][2] ? lp3_pkg::B_RD : lp3_pkg::B_WR;
			chk_banks();
		end
		$display("test bank commands done");
		final_report();
	end
endmodule

// >>> src/lp3_link_smp.sv
// Pin synchroniser and link clock edge finder for the LPDDR3 command pins.
`timescale 1ns/1ps
module lp3_link_smp (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ck,
	input  wire logic       cke,
	input  wire logic       cs_n,
	input  wire logic [9:0] ca,
	lp3_link_if.smp         l
);
	logic [3:0] ck_s;
	logic [1:0] cke_s;
	logic [1:0] cs_s;
	logic [9:0] ca_s1;
	logic [9:0] ca_s2;

	////////////////////////////////////////////////////////////////////////
	// Two flops on every pin; the later clock flops only feed edge detection.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ck_s  <= 4'h0;
			cke_s <= 2'h0;
			cs_s  <= 2'h3;
			ca_s1 <= 10'h3FF;
			ca_s2 <= 10'h3FF;
		end else begin
			ck_s  <= {ck_s[2:0], ck};
			cke_s <= {cke_s[0], cke};
			cs_s  <= {cs_s[0], cs_n};
			ca_s1 <= ca;
			ca_s2 <= ca_s1;
		end
	end

	// Strobes lag the capture by one cycle, so the decoder sees the fresh pin levels.
	assign l.rise = ck_s[2] & ~ck_s[3];
	assign l.fall = ~ck_s[2] & ck_s[3];

	////////////////////////////////////////////////////////////////////////
	// Capture CKE, chip select and the rising half of CA at each rising edge.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			l.cke_cur  <= 1'b0;
			l.cke_prev <= 1'b0;
			l.cs_n     <= 1'b1;
			l.ca_r     <= 10'h3FF;
		end else if (ck_s[1] & ~ck_s[2]) begin
			l.cke_prev <= l.cke_cur;
			l.cke_cur  <= cke_s[1];
			l.cs_n     <= cs_s[1];
			l.ca_r     <= ca_s2;
		end
	end

	// The falling half of CA carries the rest of the address and operand.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			l.ca_f <= 10'h3FF;
		end else if (~ck_s[1] & ck_s[2]) begin
			l.ca_f <= ca_s2;
		end
	end
endmodule

// >>> src/lp3_power_bank_fsm.sv
// LPDDR3 device power-state machine with per-bank command state tracking.
`timescale 1ns/1ps

// Function
// - Power transitions use CKE now, CKE at previous edge, and chip select now.
// - CKE low on both edges holds the present low-power state regardless of pins.
// - Active power down exits to Active on CKE rising with chip select high.
// - Idle power down exits to Idle on CKE rising with chip select high.
// - Resetting power down exits to Idle if init time expired, else Resetting.
// - Deep power down exits to Power On; controller then runs full exit procedure.
// - Self refresh exits to Idle; only NOPs until self refresh exit time passes.
// - Activate to an idle bank opens the row; bank becomes Active.
// - Mode register write while idle stores the register; device enters MR Writing.
// - Mode register read enters the matching MR Reading state and returns data.
// - Precharge in Idle or Active closes one or all banks into Precharging.
// - Read in Active or after a write starts a read burst; bank Reading.
// - Write in Active or after a read starts a write burst; bank Writing.
// - Read while Reading starts a new read burst and stays Reading.
// - Write while Writing starts a new write burst and stays Writing.
// - In low power, data lines float without termination or terminate when enabled.
module lp3_power_bank_fsm #(
	parameter int NBANK   = lp3_pkg::NBANK,
	parameter int C_INIT5 = lp3_pkg::C_INIT5,
	parameter int C_XSR   = lp3_pkg::C_XSR,
	parameter int C_XP    = lp3_pkg::C_XP
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        ck,
	input  wire logic        cke,
	input  wire logic        cs_n,
	input  wire logic [9:0]  ca,
	output lp3_pkg::lp3_dev_t  dev_state,
	output lp3_pkg::lp3_bank_t bank_state [NBANK],
	output logic             nop_only,
	output logic             init_done,
	output logic [7:0]       mrr_data,
	output logic             dq_oe,
	output logic             dq_term_en
);
	lp3_link_if l ();

	lp3_pkg::lp3_dev_t dev_q;
	lp3_pkg::lp3_dev_t dev_d;
	logic [lp3_pkg::TMR_W-1:0] tmr_q;
	logic [lp3_pkg::TMR_W-1:0] wait_q;
	logic [lp3_pkg::TMR_W-1:0] init_q;
	logic [7:0] mr_q [lp3_pkg::MR_N];
	logic [7:0] mrr_q;
	logic       pend_mrw_q;
	logic       pend_mrr_q;
	logic [5:0] ma_lo_q;
	logic [7:0] ma;
	logic [7:0] op;
	logic       hold;
	logic       wake;
	logic       sleep;
	logic       cmd;
	logic       c_mrw;
	logic       c_mrr;
	logic       c_refpb;
	logic       c_refab;
	logic       c_act;
	logic       c_wr;
	logic       c_rd;
	logic       c_pre;
	logic       c_sref;
	logic       c_dpd;
	logic       bank_cmd;
	logic       all_idle;
	logic       any_act;
	logic       low_pwr;
	logic       odt_on;
	logic       rst_cmd;
	logic [2:0] ba;
	logic [NBANK-1:0] b_idle;
	logic [NBANK-1:0] b_act;

	lp3_link_smp u_smp (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ck    (ck),
		.cke   (cke),
		.cs_n  (cs_n),
		.ca    (ca),
		.l     (l)
	);

	////////////////////////////////////////////////////////////////////////
	// CKE pairs classify each rising edge before any command is looked at.
	assign hold  = l.rise & ~l.cke_prev & ~l.cke_cur;
	assign wake  = l.rise & ~l.cke_prev & l.cke_cur & l.cs_n;
	assign sleep = l.rise & l.cke_prev & ~l.cke_cur;
	assign cmd   = l.rise & l.cke_prev & l.cke_cur & ~l.cs_n;

	// Opcode decode on the rising-edge half of CA, bit 0 is CA0.
	assign c_mrw   = cmd & (l.ca_r[3:0] == 4'h0);
	assign c_mrr   = cmd & (l.ca_r[3:0] == 4'h8);
	assign c_refpb = cmd & (l.ca_r[3:0] == 4'h4);
	assign c_refab = cmd & (l.ca_r[3:0] == 4'hC);
	assign c_act   = cmd & (l.ca_r[1:0] == 2'h2);
	assign c_wr    = cmd & (l.ca_r[2:0] == 3'h1);
	assign c_rd    = cmd & (l.ca_r[2:0] == 3'h5);
	assign c_pre   = cmd & (l.ca_r[3:0] == 4'hB);
	assign c_sref  = sleep & ~l.cs_n & (l.ca_r[2:0] == 3'h4);
	assign c_dpd   = sleep & ~l.cs_n & (l.ca_r[2:0] == 3'h3);
	assign ba      = l.ca_r[lp3_pkg::BA_LSB +: 3];

	// Bank commands only count once the exit wait is over; the controller owes
	// NOPs in that window, so other commands are dropped rather than trusted; self refresh and deep power down entry still act.
	assign bank_cmd = (dev_q == lp3_pkg::D_OPER) & ~nop_only;

	assign all_idle = &b_idle;
	assign any_act  = |b_act;

	// Mode register address spans both CA halves.
	assign ma      = {l.ca_f[1:0], ma_lo_q};
	assign op      = l.ca_f[9:2];
	assign rst_cmd = pend_mrw_q & l.fall & (ma == lp3_pkg::MA_RESET);

	////////////////////////////////////////////////////////////////////////
	// Device power and mode state: next-state selection.
	always_comb begin
		dev_d = dev_q;
		case (dev_q)
			lp3_pkg::D_PWRON: begin
				if (rst_cmd)
					dev_d = lp3_pkg::D_RESET;
			end
			lp3_pkg::D_RESET: begin
				if (sleep & l.cs_n)
					dev_d = lp3_pkg::D_RPD;
				else if (c_mrr)
					dev_d = lp3_pkg::D_MRRR;
				else if (init_done)
					dev_d = lp3_pkg::D_OPER;
			end
			lp3_pkg::D_OPER: begin
				if (sleep & l.cs_n)
					dev_d = any_act ? lp3_pkg::D_APD : lp3_pkg::D_IPD;
				else if (c_sref & all_idle)
					dev_d = lp3_pkg::D_SREF;
				else if (c_dpd & all_idle)
					dev_d = lp3_pkg::D_DPD;
				else if (c_mrw & all_idle & ~nop_only)
					dev_d = lp3_pkg::D_MRW;
				else if (c_mrr & ~nop_only)
					dev_d = all_idle ? lp3_pkg::D_MRRI : lp3_pkg::D_MRRA;
				else if (c_refab & all_idle & ~nop_only)
					dev_d = lp3_pkg::D_REFAB;
			end
			lp3_pkg::D_APD, lp3_pkg::D_IPD: begin
				if (wake)
					dev_d = lp3_pkg::D_OPER;
			end
			lp3_pkg::D_RPD: begin
				if (wake)
					dev_d = init_done ? lp3_pkg::D_OPER : lp3_pkg::D_RESET;
			end
			lp3_pkg::D_SREF: begin
				if (wake)
					dev_d = lp3_pkg::D_OPER;
			end
			lp3_pkg::D_DPD: begin
				if (wake)
					dev_d = lp3_pkg::D_PWRON;
			end
			lp3_pkg::D_MRW: begin
				if (rst_cmd)
					dev_d = lp3_pkg::D_RESET;
				else if (tmr_q == '0)
					dev_d = lp3_pkg::D_OPER;
			end
			lp3_pkg::D_MRRI, lp3_pkg::D_MRRA, lp3_pkg::D_REFAB: begin
				if (tmr_q == '0)
					dev_d = lp3_pkg::D_OPER;
			end
			lp3_pkg::D_MRRR: begin
				if (tmr_q == '0)
					dev_d = lp3_pkg::D_RESET;
			end
			default: dev_d = lp3_pkg::D_PWRON;
		endcase
	end

	// Device state register; low-power states change only on a wake edge.
	always_ff @(posedge mclk) begin
		if (!rst_n)
			dev_q <= lp3_pkg::D_PWRON;
		else
			dev_q <= dev_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Busy timer for mode register and all-bank refresh states.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tmr_q <= '0;
		end else if (dev_d != dev_q) begin
			case (dev_d)
				lp3_pkg::D_MRW:   tmr_q <= lp3_pkg::TMR_W'(lp3_pkg::C_MRW);
				lp3_pkg::D_REFAB: tmr_q <= lp3_pkg::TMR_W'(lp3_pkg::C_RFCAB);
				lp3_pkg::D_MRRI, lp3_pkg::D_MRRA, lp3_pkg::D_MRRR: begin
					tmr_q <= lp3_pkg::TMR_W'(lp3_pkg::C_MRR);
				end
				default: tmr_q <= '0;
			endcase
		end else if (tmr_q != '0) begin
			tmr_q <= tmr_q - 1'b1;
		end
	end

	// Exit wait: active, idle and resetting power-down exits load the short wait, self refresh the long.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wait_q <= '0;
		end else if (wake & (dev_q == lp3_pkg::D_SREF)) begin
			wait_q <= TMR_W_C(C_XSR);
		end else if (wake & (dev_q == lp3_pkg::D_APD || dev_q == lp3_pkg::D_IPD ||
				dev_q == lp3_pkg::D_RPD)) begin
			wait_q <= TMR_W_C(C_XP);
		end else if (wait_q != '0) begin
			wait_q <= wait_q - 1'b1;
		end
	end

	function automatic logic [lp3_pkg::TMR_W-1:0] TMR_W_C(input int c);
		return lp3_pkg::TMR_W'(c);
	endfunction

	// Initialisation interval: restarted by the reset command, kept running
	// through resetting power down so the exit can tell whether it expired.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			init_q <= '0;
		end else if (rst_cmd) begin
			init_q <= TMR_W_C(C_INIT5);
		end else if (init_q != '0) begin
			init_q <= init_q - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode register operands arrive on the falling half, so hold the request.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pend_mrw_q <= 1'b0;
			pend_mrr_q <= 1'b0;
			ma_lo_q    <= 6'h00;
		end else if (l.rise) begin
			pend_mrw_q <= c_mrw & (dev_q == lp3_pkg::D_PWRON ||
				(dev_q == lp3_pkg::D_OPER & all_idle & ~nop_only));
			pend_mrr_q <= c_mrr & (dev_q == lp3_pkg::D_RESET ||
				(dev_q == lp3_pkg::D_OPER & ~nop_only));
			ma_lo_q    <= l.ca_r[lp3_pkg::MA_LSB +: 6];
		end else if (l.fall) begin
			pend_mrw_q <= 1'b0;
			pend_mrr_q <= 1'b0;
		end
	end

	// Mode register file; the reset command returns every entry to default.
	always_ff @(posedge mclk) begin
		if (!rst_n || rst_cmd || (wake & dev_q == lp3_pkg::D_DPD)) begin
			for (int i = 0; i < lp3_pkg::MR_N; i++)
				mr_q[i] <= lp3_pkg::MR_RST;
		end else if (pend_mrw_q & l.fall & (ma < 8'(lp3_pkg::MR_N))) begin
			mr_q[ma[3:0]] <= op;
		end
	end

	// Read data latched at the falling half; unmapped addresses read zero.
	always_ff @(posedge mclk) begin
		if (!rst_n)
			mrr_q <= 8'h00;
		else if (pend_mrr_q & l.fall)
			mrr_q <= (ma < 8'(lp3_pkg::MR_N)) ? mr_q[ma[3:0]] : 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Per-bank command state; each bank only honours commands legal for it.
	generate
		for (genvar g = 0; g < NBANK; g++) begin : g_bank
			lp3_pkg::lp3_bank_t        st_q;
			logic [lp3_pkg::TMR_W-1:0] bt_q;
			logic                      hit;
			logic                      pre_hit;

			assign hit     = bank_cmd & (ba == 3'(g));
			assign pre_hit = bank_cmd & c_pre & (l.ca_r[lp3_pkg::AB_BIT] | ba == 3'(g));

			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					st_q <= lp3_pkg::B_IDLE;
					bt_q <= '0;
				end else begin
					case (st_q)
						lp3_pkg::B_IDLE: begin
							if (hit & c_act) begin
								st_q <= lp3_pkg::B_ACT;
							end else if (pre_hit) begin
								st_q <= lp3_pkg::B_PRE;
								bt_q <= TMR_W_C(lp3_pkg::C_RP);
							end else if (hit & c_refpb) begin
								st_q <= lp3_pkg::B_REF;
								bt_q <= TMR_W_C(lp3_pkg::C_RFCPB);
							end
						end
						lp3_pkg::B_ACT, lp3_pkg::B_RD, lp3_pkg::B_WR: begin
							if (pre_hit) begin
								st_q <= lp3_pkg::B_PRE;
								bt_q <= TMR_W_C(lp3_pkg::C_RP);
							end else if (hit & c_rd) begin
								st_q <= lp3_pkg::B_RD;
							end else if (hit & c_wr) begin
								st_q <= lp3_pkg::B_WR;
							end
						end
						lp3_pkg::B_PRE, lp3_pkg::B_REF: begin
							if (bt_q == '0)
								st_q <= lp3_pkg::B_IDLE;
							else
								bt_q <= bt_q - 1'b1;
						end
						default: st_q <= lp3_pkg::B_IDLE;
					endcase
				end
			end

			assign b_idle[g]     = (st_q == lp3_pkg::B_IDLE);
			assign b_act[g]      = ~b_idle[g];
			assign bank_state[g] = st_q;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Data pins: driven only while mode register data is returned; in low
	// power they float, or are terminated when ODT is set in its register.
	assign low_pwr = (dev_q == lp3_pkg::D_APD) | (dev_q == lp3_pkg::D_IPD) |
		(dev_q == lp3_pkg::D_RPD) | (dev_q == lp3_pkg::D_SREF) | (dev_q == lp3_pkg::D_DPD);
	assign odt_on  = |mr_q[lp3_pkg::MA_ODT[3:0]][1:0];

	assign dq_oe      = (dev_q == lp3_pkg::D_MRRI) | (dev_q == lp3_pkg::D_MRRA) |
		(dev_q == lp3_pkg::D_MRRR);
	assign dq_term_en = low_pwr & odt_on;
	assign dev_state  = dev_q;
	assign nop_only   = (wait_q != '0);
	assign init_done  = (init_q == '0);
	assign mrr_data   = mrr_q;
endmodule
